/* bench/bus_master_model.sv */
`timescale 1ns/1ps
// ****************************************
// Processor or controller side of the bus
// ****************************************
module bus_master_model (
    input  wire logic                   clk,
    output burst_sram_pkg::start_ctl_t  start_ctl,
    output burst_sram_pkg::write_ctl_t  write_ctl,
    output logic                        burst_advance_n,
    output logic                        burst_mode,
    output logic [17:0]                 ext_addr,
    output logic [35:0]                 data_in
);
    initial begin
        start_ctl       = 5'h1e;
        write_ctl       = 6'h3f;
        burst_advance_n = 1'b1;
        burst_mode      = 1'b1;
        ext_addr        = 18'h0_0000;
        data_in         = 36'h0_0000_0000;
    end
    // Only called while the memory is held in reset
    task automatic set_mode(input logic m);
        @(posedge clk);
        burst_mode <= m;
    endtask : set_mode
    // One bus cycle, launched just after a rising edge
    task automatic drive(input logic [4:0] s, input logic [5:0] w, input logic adv,
                         input logic [17:0] a, input logic [35:0] d);
        @(posedge clk);
        start_ctl       <= s;
        write_ctl       <= w;
        burst_advance_n <= adv;
        ext_addr        <= a;
        data_in         <= d;
    endtask : drive
endmodule : bus_master_model

/* bench/tb_burst_sram_address_control.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module tb_burst_sram_address_control;
    typedef struct packed {
        logic [4:0]  s;
        logic [5:0]  w;
        logic [17:0] a;
        logic        rd;
        logic        wr;
        logic        pd;
        logic [3:0]  ln;
    } row_t;
    // ****************************************
    // Clock, design and bus model
    // ****************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sleep_request = 1'b0;
    int   errors = 0;
    int   n_checks = 0;
    int   cycles = 0;
    burst_sram_pkg::start_ctl_t start_ctl;
    burst_sram_pkg::write_ctl_t write_ctl;
    logic burst_advance_n, burst_mode, write_valid, read_valid, powered_down, asleep;
    logic [17:0] ext_addr, mem_addr;
    logic [35:0] data_in;
    logic [31:0] wr_data;
    logic [3:0]  lane_write_en, parity_write_en, wr_parity;
    localparam logic [17:0] BURST_BASE = 18'h2_aa81;
    row_t rows [9] = '{
        '{5'h16, 6'h3f, 18'h0_0000, 1'b0, 1'b0, 1'b1, 4'h0},
        '{5'h0e, 6'h3f, 18'h0_0000, 1'b0, 1'b0, 1'b1, 4'h0},
        '{5'h08, 6'h3f, 18'h0_0000, 1'b0, 1'b0, 1'b1, 4'h0},
        '{5'h0b, 6'h3f, 18'h0_0000, 1'b0, 1'b0, 1'b1, 4'h0},
        '{5'h0a, 6'h3f, 18'h0_0155, 1'b1, 1'b0, 1'b0, 4'h0},
        '{5'h02, 6'h1f, 18'h1_0a0a, 1'b1, 1'b0, 1'b0, 4'h0},
        '{5'h12, 6'h1f, 18'h3_0003, 1'b0, 1'b1, 1'b0, 4'hf},
        '{5'h12, 6'h2a, 18'h0_4440, 1'b0, 1'b1, 1'b0, 4'h5},
        '{5'h12, 6'h3f, 18'h2_0001, 1'b1, 1'b0, 1'b0, 4'h0}};
    initial begin
        forever #5 clk = ~clk;
    end
    burst_sram_address_control #(.ADDR_W(18), .WIDTH(2'h2)) burst_sram_address_control_i (
        .clk(clk), .rst(rst), .start_ctl(start_ctl), .write_ctl(write_ctl),
        .burst_advance_n(burst_advance_n), .burst_mode(burst_mode),
        .sleep_request(sleep_request), .ext_addr(ext_addr), .data_in(data_in),
        .mem_addr(mem_addr), .lane_write_en(lane_write_en),
        .parity_write_en(parity_write_en), .wr_data(wr_data), .wr_parity(wr_parity),
        .write_valid(write_valid), .read_valid(read_valid),
        .powered_down(powered_down), .asleep(asleep));
    bus_master_model bus_master_model_i (
        .clk(clk), .start_ctl(start_ctl), .write_ctl(write_ctl),
        .burst_advance_n(burst_advance_n), .burst_mode(burst_mode),
        .ext_addr(ext_addr), .data_in(data_in));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    task automatic do_reset(input logic m);
        @(posedge clk);
        rst <= 1'b1;
        bus_master_model_i.set_mode(m);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK("reset read", 1'b0, read_valid)
        `CHK("reset write", 1'b0, write_valid)
        `CHK("reset down", 1'b0, powered_down)
    endtask : do_reset
    // Load, three steps, then a wait state that must hold the address
    task automatic burst(input logic lin);
        int         c;
        logic [1:0] lo;
        for (int k = 0; k < 6; k++) begin
            bus_master_model_i.drive(k == 0 ? 5'h0a : 5'h1e, 6'h3f, k == 0 || k >= 4,
                                     BURST_BASE, {4'(k), 32'h1234_5670 + 32'(k)});
            if (k > 0) begin
                #1;
                c = (k == 5) ? 3 : k - 1;
                lo = lin ? BURST_BASE[1:0] + 2'(c) : BURST_BASE[1:0] ^ 2'(c);
                `CHK("burst addr", {BURST_BASE[17:2], lo}, mem_addr)
                `CHK("wr_data", 32'h1234_5670 + 32'(k - 1), wr_data)
                `CHK("wr_parity", 4'(k - 1), wr_parity)
            end
        end
    endtask : burst
    // ****************************************
    // Sequence and timeout
    // ****************************************
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        do_reset(1'b1);
        for (int i = 0; i < 9; i++) begin
            bus_master_model_i.drive(rows[i].s, rows[i].w, 1'b1, rows[i].a, 36'h0_0000_0000);
            bus_master_model_i.drive(5'h1e, 6'h3f, 1'b1, 18'h3_ffff, 36'h0_0000_0000);
            #1;
            `CHK("read_valid", rows[i].rd, read_valid)
            `CHK("write_valid", rows[i].wr, write_valid)
            `CHK("powered_down", rows[i].pd, powered_down)
            `CHK("lane_write_en", rows[i].ln, lane_write_en)
            `CHK("parity_write_en", rows[i].ln, parity_write_en)
            if (rows[i].rd | rows[i].wr) `CHK("mem_addr", rows[i].a, mem_addr)
        end
        burst(1'b0);
        do_reset(1'b0);
        burst(1'b1);
        print_verdict();
    end
endmodule : tb_burst_sram_address_control

/* rtl/burst_sram_address_control.sv */
`timescale 1ns/1ps
`include "burst_sram_params.svh"
module burst_sram_address_control #(
    parameter int                    ADDR_W = `BSR_ADDR_W,
    parameter logic [1:0]            WIDTH  = `BSR_WIDTH_X36
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire burst_sram_pkg::start_ctl_t start_ctl,
    input  wire burst_sram_pkg::write_ctl_t write_ctl,
    input  wire logic                burst_advance_n,
    input  wire logic                burst_mode,
    input  wire logic                sleep_request,
    input  wire logic [ADDR_W-1:0]   ext_addr,
    input  wire logic [35:0]         data_in,
    output logic [ADDR_W-1:0]        mem_addr,
    output logic [3:0]               lane_write_en,
    output logic [3:0]               parity_write_en,
    output logic [31:0]              wr_data,
    output logic [3:0]               wr_parity,
    output logic                     write_valid,
    output logic                     read_valid,
    output logic                     powered_down,
    output logic                     asleep
);
    import burst_sram_pkg::*;

    // ****************************************
    // Lane layout
    // ****************************************
    localparam logic [3:0] LANES_PRESENT = (WIDTH == `BSR_WIDTH_X18) ? 4'h3 : 4'hf;
    localparam logic [3:0] PARITY_PRESENT =
        (WIDTH == `BSR_WIDTH_X32) ? 4'h0 : LANES_PRESENT;

    // ****************************************
    // Start decode
    // ****************************************
    logic                sleep_s1_r, sleep_s2_r;
    op_state_t           state_r, state_nxt;
    logic [ADDR_W-1:0]   base_r;
    logic [1:0]          count_r, count_nxt;
    logic                mode_r;
    logic                load;
    logic                proc_start;
    logic                ctrl_start;
    logic                sec_ok;
    logic                is_write;

    always_ff @(posedge clk) begin
        sleep_s1_r <= sleep_request;
        sleep_s2_r <= sleep_s1_r;
    end

    assign sec_ok     = start_ctl.secondary_hi && !start_ctl.secondary_n;
    assign proc_start = !start_ctl.proc_strobe_n && !start_ctl.primary_n;
    assign ctrl_start = !start_ctl.ctrl_strobe_n && !proc_start;
    assign load       = proc_start || ctrl_start;
    assign is_write   = !write_ctl.full_word_write_n ||
                        (!write_ctl.byte_write_gate_n && (write_ctl.lane_write_n != 4'hf));

    always_comb begin
        state_nxt = state_r;
        if (sleep_s2_r) begin
            state_nxt = ST_SLEEP;
        end else if (proc_start) begin
            state_nxt = sec_ok ? ST_READ : ST_SLEEP;
        end else if (ctrl_start) begin
            if (start_ctl.primary_n || !sec_ok) begin
                state_nxt = ST_SLEEP;
            end else begin
                state_nxt = is_write ? ST_WRITE : ST_READ;
            end
        end else if (state_r == ST_READ || state_r == ST_WRITE) begin
            state_nxt = is_write ? ST_WRITE : ST_READ;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // Burst counter
    // ****************************************
    always_comb begin
        count_nxt = count_r;
        if (load) begin
            count_nxt = `BSR_COUNT_RST;
        end else if (!burst_advance_n) begin
            count_nxt = count_r + `BSR_COUNT_STEP;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_r <= `BSR_COUNT_RST;
            base_r  <= '0;
            mode_r  <= 1'b1;
        end else begin
            count_r <= count_nxt;
            mode_r  <= burst_mode;
            if (load && !sleep_s2_r) begin
                base_r <= ext_addr;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mem_addr <= '0;
        end else if (load) begin
            mem_addr <= ext_addr;
        end else if (mode_r) begin
            mem_addr <= {base_r[ADDR_W-1:2], base_r[1:0] ^ count_nxt};
        end else begin
            mem_addr <= {base_r[ADDR_W-1:2], base_r[1:0] + count_nxt};
        end
    end

    // ****************************************
    // Write lanes and data capture
    // ****************************************
    logic [3:0] lane_sel;
    logic       wr_ok;
    assign wr_ok    = (state_nxt == ST_WRITE) && !proc_start;
    assign lane_sel = !write_ctl.full_word_write_n ? 4'hf :
                      (!write_ctl.byte_write_gate_n ? ~write_ctl.lane_write_n : 4'h0);

    always_ff @(posedge clk) begin
        if (rst) begin
            lane_write_en   <= 4'h0;
            parity_write_en <= 4'h0;
            wr_data         <= '0;
            wr_parity       <= 4'h0;
            write_valid     <= 1'b0;
            read_valid      <= 1'b0;
        end else begin
            lane_write_en   <= wr_ok ? (lane_sel & LANES_PRESENT) : 4'h0;
            parity_write_en <= wr_ok ? (lane_sel & PARITY_PRESENT) : 4'h0;
            wr_data         <= data_in[31:0];
            wr_parity       <= data_in[35:32] & PARITY_PRESENT;
            write_valid     <= wr_ok;
            read_valid      <= (state_nxt == ST_READ);
        end
    end

    assign powered_down = (state_r == ST_SLEEP);
    assign asleep       = sleep_s2_r;

    // ****************************************
    // Checks
    // ****************************************
    proc_read_a: assert property (@(posedge clk) disable iff (rst)
        proc_start && sec_ok && !sleep_s2_r |=> read_valid && !write_valid && mem_addr == $past(ext_addr))
        else $error("processor strobe did not start a read");
    proc_ignore_a: assert property (@(posedge clk) disable iff (rst)
        !start_ctl.proc_strobe_n && start_ctl.primary_n && start_ctl.ctrl_strobe_n && !sleep_s2_r
        && state_r == ST_IDLE |=> state_r == ST_IDLE)
        else $error("processor strobe not ignored");
    proc_down_a: assert property (@(posedge clk) disable iff (rst)
        proc_start && !sec_ok |=> powered_down)
        else $error("no power-down on secondary deselect");
    ctrl_load_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_start && !start_ctl.primary_n && sec_ok && !sleep_s2_r |=> mem_addr == $past(ext_addr)
        && (read_valid || write_valid))
        else $error("controller strobe did not load");
    ctrl_down_a: assert property (@(posedge clk) disable iff (rst)
        !start_ctl.ctrl_strobe_n && start_ctl.primary_n |=> powered_down)
        else $error("controller deselect missed");
    burst_hold_a: assert property (@(posedge clk) disable iff (rst)
        !load && burst_advance_n |=> $stable(count_r))
        else $error("counter moved on wait");
    lane_x32_a: assert property (@(posedge clk) disable iff (rst)
        WIDTH == `BSR_WIDTH_X32 |-> parity_write_en == 4'h0 && wr_parity == 4'h0)
        else $error("parity lane active on x32");
    full_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_ok && !write_ctl.full_word_write_n |=> lane_write_en == LANES_PRESENT)
        else $error("full word write incomplete");
    data_cap_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> wr_data == $past(data_in[31:0]))
        else $error("write data not captured");
endmodule : burst_sram_address_control

/* rtl/burst_sram_params.svh */
`ifndef BURST_SRAM_PARAMS_SVH
`define BURST_SRAM_PARAMS_SVH
// ****************************************
// Widths and burst constants
// ****************************************
`define BSR_ADDR_W      18
`define BSR_BURST_W     2
`define BSR_LANE_BITS   8
`define BSR_WIDTH_X18   2'h0
`define BSR_WIDTH_X32   2'h1
`define BSR_WIDTH_X36   2'h2
`define BSR_COUNT_RST   2'h0
`define BSR_COUNT_STEP  2'h1
`endif

/* rtl/burst_sram_pkg.sv */
`include "burst_sram_params.svh"
package burst_sram_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b11,
        ST_SLEEP = 2'b10
    } op_state_t;

    typedef struct packed {
        logic proc_strobe_n;
        logic ctrl_strobe_n;
        logic primary_n;
        logic secondary_hi;
        logic secondary_n;
    } start_ctl_t;

    typedef struct packed {
        logic       full_word_write_n;
        logic       byte_write_gate_n;
        logic [3:0] lane_write_n;
    } write_ctl_t;
endpackage : burst_sram_pkg
